// ---- gbc_pkg.sv ----
// Purpose : shared constants and carriers for the gain and balance control manager
// Assumes : gain and balance are held in signed tenths of a decibel
// Notes   : register offsets are byte addresses on the plain register port
package gbc_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ        = 125000;
    localparam int HOLD_MS        = 1000;                 // paddle hold before fast repeat
    localparam int REPEAT_MS      = 50;                   // fast repeat period
    localparam int HOLD_CYC_DEF   = HOLD_MS * CLK_KHZ;
    localparam int REPEAT_CYC_DEF = REPEAT_MS * CLK_KHZ;
    localparam int CNT_W          = 28;
    localparam logic [1:0] BOOT_WAIT = 2'h3;              // lets the pin synchronisers fill

    // ----------------------------------------------------------------
    // gain ranges in 0.1 dB units
    // ----------------------------------------------------------------
    localparam int GAIN_W = 12;
    localparam int BAL_W  = 8;
    localparam int POT_W  = 8;
    localparam logic signed [12:0] GAIN_MIN = -13'sd200;   // -20 dB
    localparam logic signed [12:0] GAIN_MAX = 13'sd300;    // +30 dB
    localparam logic signed [12:0] BAL_LIM  = 13'sd60;     // +6 dB to the favoured channel
    localparam logic signed [12:0] POT_LIM  = 13'sd60;     // +/-6 dB fine trim

    // ----------------------------------------------------------------
    // output source codes (two bits per channel)
    // ----------------------------------------------------------------
    localparam logic [1:0] SRC_IN1 = 2'h0;
    localparam logic [1:0] SRC_IN2 = 2'h1;
    localparam logic [1:0] SRC_SUM = 2'h2;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_REM_GAIN  = 8'h00;
    localparam logic [7:0] REG_REM_BAL   = 8'h04;
    localparam logic [7:0] REG_REM_ROUTE = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0c;
    localparam logic [7:0] REG_CH_GAIN   = 8'h10;
    localparam int ROUTE_PHASE_LSB = 4;

    typedef enum logic [0:0] {
        ST_BOOT = 1'b0,
        ST_RUN  = 1'b1
    } mgr_state_t;

    typedef struct packed {
        logic       [1:0] phase;      // bit0 ch1, bit1 ch2; 1 = inverted
        logic       [3:0] out_sel;    // [1:0] ch1 source, [3:2] ch2 source
    } route_t;

    typedef struct packed {
        logic              bal_up;
        logic              bal_dn;
        logic              gain_up;
        logic              gain_dn;
        logic              local_only;   // control source jumper: 1 = local only
        route_t            route;        // output select and phase jumpers
        logic signed [7:0] fine_gain;
        logic signed [7:0] fine_bal;
    } pins_t;

    typedef struct packed {
        logic                     local_only;
        route_t                   route;
        logic                     rem_valid;
        logic signed [GAIN_W-1:0] rem_gain;
        logic signed [BAL_W-1:0]  rem_bal;
        route_t                   rem_route;
    } nv_snap_t;

endpackage

// ---- gain_balance_control_manager.sv ----
// Purpose : gain, balance, routing and override control for a remote-capable stereo audio module
// Assumes : paddle, jumper and pot inputs are asynchronous pins; nv snapshot port is on core_clk_i
// Notes   : all gains in signed 0.1 dB units; outputs are registered
`timescale 1ns/1ps

module gain_balance_control_manager
    import gbc_pkg::*;
#(
    parameter int HOLD_CYC   = gbc_pkg::HOLD_CYC_DEF,
    parameter int REPEAT_CYC = gbc_pkg::REPEAT_CYC_DEF
) (
    input  wire logic                         core_clk_i,            // 125 MHz clock
    input  wire logic                         sys_rst_i,             // async reset, active high
    input  wire gbc_pkg::pins_t               pins_i,                // paddles, jumpers, pots
    input  wire logic [gbc_pkg::ADDR_W-1:0]   addr_i,                // register byte address
    input  wire logic [31:0]                  wr_data_i,             // register write data
    input  wire logic                         wr_i,                  // write strobe
    input  wire logic                         rd_i,                  // read strobe
    output logic      [31:0]                  rd_data_o,             // read data, cycle after rd_i
    input  wire logic                         nv_valid_i,            // snapshot store holds data
    input  wire gbc_pkg::nv_snap_t            nv_snap_i,             // stored snapshot
    output gbc_pkg::nv_snap_t                 nv_snap_o,             // snapshot to store
    output logic                              nv_save_o,             // pulse: store nv_snap_o
    output logic signed [gbc_pkg::GAIN_W-1:0] ch1_gain_o,            // channel 1 gain
    output logic signed [gbc_pkg::GAIN_W-1:0] ch2_gain_o,            // channel 2 gain
    output gbc_pkg::route_t                   route_o,               // sources and phase
    output logic                              override_indicator_o,  // remote overrides local
    output logic                              local_only_mode_o,     // synced mode jumper
    output logic                              ready_o                // boot compare finished
);
    import gbc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        mgr_state_t               st;
        logic [1:0]               boot_cnt;
        pins_t                    sy1;
        pins_t                    sy2;
        logic                     act_prev;
        logic [CNT_W-1:0]         hold_cnt;
        logic [CNT_W-1:0]         rep_cnt;
        logic signed [GAIN_W-1:0] loc_gain;
        logic signed [BAL_W-1:0]  loc_bal;
        logic                     rem_valid;
        logic signed [GAIN_W-1:0] rem_gain;
        logic signed [BAL_W-1:0]  rem_bal;
        route_t                   rem_route;
        logic [31:0]              rd_data;
        logic                     nv_save;
        logic signed [GAIN_W-1:0] ch1_gain;
        logic signed [GAIN_W-1:0] ch2_gain;
        route_t                   route;
        logic                     override_indicator;
    } mgr_t;

    mgr_t s;
    mgr_t n;

    pins_t                    p;
    logic                     bal_centre;
    logic                     act;
    logic                     step;
    logic signed [12:0]       dg;
    logic signed [12:0]       db;
    logic                     use_rem;
    logic signed [12:0]       eg;
    logic signed [12:0]       eb;
    logic signed [12:0]       pg;
    logic signed [12:0]       pb;
    route_t                   er;
    logic                     jmp_match;

    function automatic logic signed [12:0] clamp(input logic signed [12:0] v,
                                                 input logic signed [12:0] lo,
                                                 input logic signed [12:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // an unused select code falls back to input 1 rather than muting the output
    function automatic route_t fix_route(input route_t r);
        route_t f;
        f = r;
        for (int c = 0; c < 2; c++) begin
            if (r.out_sel[2*c +: 2] != SRC_IN2 && r.out_sel[2*c +: 2] != SRC_SUM) begin
                f.out_sel[2*c +: 2] = SRC_IN1;
            end
        end
        return f;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n         = s;
        n.nv_save = 1'b0;
        n.rd_data = 32'h0;
        n.sy1     = pins_i;
        n.sy2     = s.sy1;
        p         = s.sy2;
        step      = 1'b0;
        dg        = 13'sh0;
        db        = 13'sh0;

        // paddle decode; both contacts at once counts as no press
        bal_centre = !p.bal_up && !p.bal_dn;
        act        = (p.bal_up ^ p.bal_dn) || (bal_centre && (p.gain_up ^ p.gain_dn));
        jmp_match  = nv_snap_i.local_only == p.local_only && nv_snap_i.route == p.route;

        case (s.st)
            ST_BOOT: begin
                n.boot_cnt = s.boot_cnt + 2'h1;
                if (s.boot_cnt == BOOT_WAIT) begin
                    n.st = ST_RUN;
                    if (nv_valid_i && jmp_match && nv_snap_i.rem_valid) begin
                        n.rem_valid = 1'b1;
                        n.rem_gain  = nv_snap_i.rem_gain;
                        n.rem_bal   = nv_snap_i.rem_bal;
                        n.rem_route = nv_snap_i.rem_route;
                    end else begin
                        n.rem_valid = 1'b0;
                        n.nv_save   = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // first press steps at once; after the hold time steps repeat fast
                if (!act) begin
                    n.hold_cnt = '0;
                    n.rep_cnt  = '0;
                end else if (!s.act_prev) begin
                    step       = 1'b1;
                    n.hold_cnt = '0;
                    n.rep_cnt  = '0;
                end else if (s.hold_cnt < CNT_W'(HOLD_CYC)) begin
                    n.hold_cnt = s.hold_cnt + 1'b1;
                end else if (s.rep_cnt >= CNT_W'(REPEAT_CYC - 1)) begin
                    step      = 1'b1;
                    n.rep_cnt = '0;
                end else begin
                    n.rep_cnt = s.rep_cnt + 1'b1;
                end

                if (step && p.bal_up && !p.bal_dn) begin
                    db = 13'sh1;
                end else if (step && p.bal_dn && !p.bal_up) begin
                    db = -13'sh1;
                end else if (step && bal_centre && p.gain_up && !p.gain_dn) begin
                    dg = 13'sh1;
                end else if (step && bal_centre && p.gain_dn && !p.gain_up) begin
                    dg = -13'sh1;
                end

                // gain steps leave balance untouched so the offset survives
                n.loc_gain = GAIN_W'(clamp(13'(s.loc_gain) + dg, GAIN_MIN, GAIN_MAX));
                n.loc_bal  = BAL_W'(clamp(13'(s.loc_bal) + db, -BAL_LIM, BAL_LIM));
                if (s.rem_valid && !p.local_only) begin
                    n.rem_gain = GAIN_W'(clamp(13'(s.rem_gain) + dg, GAIN_MIN, GAIN_MAX));
                    n.rem_bal  = BAL_W'(clamp(13'(s.rem_bal) + db, -BAL_LIM, BAL_LIM));
                end

                // remote writes; a first write seeds the remote set from local
                if (wr_i && !p.local_only) begin
                    // only a mapped write may seed, so an unmapped one leaves no trace
                    if (!s.rem_valid && (addr_i == REG_REM_GAIN || addr_i == REG_REM_BAL
                                         || addr_i == REG_REM_ROUTE)) begin
                        n.rem_gain  = s.loc_gain;
                        n.rem_bal   = s.loc_bal;
                        n.rem_route = p.route;
                    end
                    case (addr_i)
                        REG_REM_GAIN: begin
                            n.rem_valid = 1'b1;
                            n.rem_gain  = GAIN_W'(clamp(13'($signed(wr_data_i[12:0])), GAIN_MIN, GAIN_MAX));
                            n.nv_save   = 1'b1;
                        end
                        REG_REM_BAL: begin
                            n.rem_valid = 1'b1;
                            n.rem_bal   = BAL_W'(clamp(13'($signed(wr_data_i[12:0])), -BAL_LIM, BAL_LIM));
                            n.nv_save   = 1'b1;
                        end
                        REG_REM_ROUTE: begin
                            n.rem_valid = 1'b1;
                            n.rem_route = wr_data_i[5:0];
                            n.nv_save   = 1'b1;
                        end
                        default: begin
                            n.rem_valid = s.rem_valid;
                        end
                    endcase
                end
            end
            default: begin
                n.st = ST_BOOT;
            end
        endcase
        n.act_prev = (s.st == ST_RUN) && act;

        // register reads; unmapped addresses read as zero
        if (rd_i) begin
            case (addr_i)
                REG_REM_GAIN:  n.rd_data = 32'($signed(s.rem_gain));
                REG_REM_BAL:   n.rd_data = 32'($signed(s.rem_bal));
                REG_REM_ROUTE: n.rd_data = {26'h0, s.rem_route};
                REG_STATUS:    n.rd_data = {28'h0, s.override_indicator, s.rem_valid, p.local_only, s.st == ST_RUN};
                REG_CH_GAIN:   n.rd_data = {16'($signed(s.ch2_gain)), 16'($signed(s.ch1_gain))};
                default:       n.rd_data = 32'h0;
            endcase
        end

        // effective settings
        use_rem = !p.local_only && n.rem_valid;
        eg      = use_rem ? 13'(n.rem_gain) : 13'(n.loc_gain);
        eb      = use_rem ? 13'(n.rem_bal) : 13'(n.loc_bal);
        er      = use_rem ? n.rem_route : p.route;
        pg      = p.local_only ? clamp(13'(p.fine_gain), -POT_LIM, POT_LIM) : 13'sh0;
        pb      = p.local_only ? clamp(13'(p.fine_bal), -POT_LIM, POT_LIM) : 13'sh0;
        n.ch1_gain = GAIN_W'(eg + eb + pg + pb);
        n.ch2_gain = GAIN_W'(eg - eb + pg - pb);
        n.route    = fix_route(er);
        n.override_indicator      = (n.st == ST_RUN) && use_rem
                     && (n.rem_route != p.route || n.rem_gain != n.loc_gain
                         || n.rem_bal != n.loc_bal);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rd_data_o            = s.rd_data;
    assign nv_save_o            = s.nv_save;
    assign ch1_gain_o           = s.ch1_gain;
    assign ch2_gain_o           = s.ch2_gain;
    assign route_o              = s.route;
    assign override_indicator_o = s.override_indicator;
    assign local_only_mode_o    = s.sy2.local_only;
    assign ready_o              = s.st == ST_RUN;
    assign nv_snap_o            = '{local_only: s.sy2.local_only, route: s.sy2.route,
                                    rem_valid: s.rem_valid, rem_gain: s.rem_gain,
                                    rem_bal: s.rem_bal, rem_route: s.rem_route};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence boot_resume_s;
        s.st == ST_BOOT && s.boot_cnt == BOOT_WAIT && nv_valid_i && jmp_match && nv_snap_i.rem_valid;
    endsequence

    sequence boot_local_s;
        s.st == ST_BOOT && s.boot_cnt == BOOT_WAIT && !(nv_valid_i && jmp_match && nv_snap_i.rem_valid);
    endsequence

    chk_local_write_drop: assert property (s.sy2.local_only && wr_i |=> $stable(s.rem_gain)
        && $stable(s.rem_bal) && $stable(s.rem_route) && $stable(s.rem_valid))
        else $error("remote write changed settings in local-only mode");

    chk_remote_write_take: assert property (s.st == ST_RUN && !s.sy2.local_only && wr_i
        && addr_i == REG_REM_ROUTE |=> s.rem_valid && s.rem_route == $past(wr_data_i[5:0]))
        else $error("remote route write not taken");

    chk_ovr_local_off: assert property (s.sy2.local_only |=> !override_indicator_o)
        else $error("override lit in local-only mode");

    chk_pot_ignored: assert property (!s.sy2.local_only && !n.rem_valid && s.st == ST_RUN
        |=> ch1_gain_o == GAIN_W'(13'(s.loc_gain) + 13'(s.loc_bal)))
        else $error("fine pots affected gain outside local-only mode");

    chk_bal_limit: assert property (s.loc_bal <= 8'sd60 && s.loc_bal >= -8'sd60
        && s.rem_bal <= 8'sd60 && s.rem_bal >= -8'sd60)
        else $error("balance beyond six decibels");

    chk_bal_step: assert property ($changed(s.loc_bal) |-> (s.loc_bal - $past(s.loc_bal) == 8'sd1
        && $past(s.sy2.bal_up)) || (s.loc_bal - $past(s.loc_bal) == -8'sd1 && $past(s.sy2.bal_dn)))
        else $error("balance step wrong size or direction");

    chk_gain_centre: assert property ($changed(s.loc_gain) |-> $past(!s.sy2.bal_up && !s.sy2.bal_dn)
        && (s.loc_gain - $past(s.loc_gain) == 12'sd1 || s.loc_gain - $past(s.loc_gain) == -12'sd1))
        else $error("common gain moved off centre or by wrong step");

    chk_boot_resume: assert property (boot_resume_s |-> ##1 s.rem_valid
        && s.rem_gain == $past(nv_snap_i.rem_gain) ##1 (override_indicator_o
        || s.sy2.local_only || s.rem_route == s.sy2.route))
        else $error("remote settings not resumed after power-up");

    chk_boot_local: assert property (boot_local_s |-> ##1 !s.rem_valid && nv_save_o
        ##1 !override_indicator_o)
        else $error("changed jumpers did not start local");

    chk_route_local: assert property (s.sy2.local_only ##1 s.sy2.local_only
        |-> route_o.phase == $past(s.sy2.route.phase))
        else $error("phase output does not follow jumper");

endmodule // gain_balance_control_manager

// ---- nv_store_model.sv ----
// Purpose: nonvolatile snapshot store beside the control manager
// Assumes: stores on the clock edge that sees the save pulse
// Notes:   no reset, so contents survive a power cycle
`timescale 1ns/1ps
module nv_store_model
    import gbc_pkg::*;
(
    input  wire logic              core_clk_i,  // module clock
    input  wire logic              nv_save_i,   // store request pulse
    input  wire gbc_pkg::nv_snap_t nv_snap_i,   // snapshot to keep
    output logic                   nv_valid_o,  // store holds data
    output gbc_pkg::nv_snap_t      nv_snap_o    // kept snapshot
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic     valid_ff = 1'b0;
    nv_snap_t snap_ff  = '0;
    always @(posedge core_clk_i) begin
        if (nv_save_i === 1'b1) begin
            valid_ff <= 1'b1;
            snap_ff  <= nv_snap_i;
        end
    end
    assign nv_valid_o = valid_ff;
    assign nv_snap_o  = snap_ff;
endmodule // nv_store_model

// ---- testbench.sv ----
// Purpose: self-checking bench for the gain and balance control manager
// Assumes: short hold and repeat counts
// Notes:   jumpers only change while reset is held
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import gbc_pkg::*;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    pins_t                    pins = '0;
    pins_t                    jp;
    logic [7:0]               addr = 8'h00;
    logic [31:0]              wdat = 32'h0;
    logic                     wr = 1'b0;
    logic                     rd = 1'b0;
    logic [31:0]              rdat;
    logic [31:0]              d;
    logic                     nv_v, save, override_indicator, rdy, loc_mode;
    nv_snap_t                 nv_in, nv_out;
    logic signed [GAIN_W-1:0] g1, g2;
    route_t                   route;
    int                       miscompares = 0;
    int                       samples_checked = 0;
    int                       n;

    always #4 clk = ~clk;

    gain_balance_control_manager #(.HOLD_CYC(20), .REPEAT_CYC(4)) uut (
        .core_clk_i(clk), .sys_rst_i(rst), .pins_i(pins), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
        .nv_valid_i(nv_v), .nv_snap_i(nv_in), .nv_snap_o(nv_out),
        .nv_save_o(save), .ch1_gain_o(g1), .ch2_gain_o(g2), .route_o(route),
        .override_indicator_o(override_indicator), .local_only_mode_o(loc_mode), .ready_o(rdy));
    nv_store_model store (.core_clk_i(clk), .nv_save_i(save), .nv_snap_i(nv_out),
        .nv_valid_o(nv_v), .nv_snap_o(nv_in));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wr   <= 1'b1;
        @(posedge clk);
        wr   <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdat;
    endtask
    // jumpers move only with the module held in reset, like an unpowered card
    task automatic boot(input pins_t p);
        @(posedge clk);
        rst  <= 1'b1;
        pins <= p;
        tick(12);
        rst <= 1'b0;
        n = 0;
        while (rdy !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) begin
            miscompares++;
            end_of_test();
        end
        tick(3);
    endtask
    task automatic hold(input logic [3:0] pd, input int k);
        @(posedge clk);
        {pins.bal_up, pins.bal_dn, pins.gain_up, pins.gain_dn} <= pd;
        tick(k);
        {pins.bal_up, pins.bal_dn, pins.gain_up, pins.gain_dn} <= 4'h0;
        tick(4);
    endtask
    task automatic gains(input logic signed [GAIN_W-1:0] a, b);
        `CHK(g1, a)
        `CHK(g2, b)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end
    initial begin
        jp = '0;
        jp.local_only = 1'b1;
        jp.route = 6'h26;
        jp.fine_gain = 8'sd10;
        jp.fine_bal = 8'sd5;
        boot(jp);
        gains(15, 5);
        `CHK(route, 6'h26)
        `CHK(loc_mode, 1'b1)
        wr_reg(REG_REM_GAIN, 32'd50);
        tick(3);
        gains(15, 5);
        rd_reg(REG_STATUS);
        `CHK(d, 32'h3)
        @(posedge clk);
        pins.fine_gain <= 8'sd100;
        tick(6);
        gains(65, 55);
        jp.local_only = 1'b0;
        jp.fine_gain = 8'sd100;
        boot(jp);
        gains(0, 0);
        `CHK(loc_mode, 1'b0)
        hold(4'h8, 3);
        gains(1, -1);
        hold(4'h8, 400);
        gains(60, -60);
        hold(4'h4, 800);
        gains(-60, 60);
        hold(4'h6, 3);
        gains(-60, 60);
        hold(4'h2, 3);
        gains(-59, 61);
        hold(4'h1, 3);
        gains(-60, 60);
        wr_reg(REG_REM_GAIN, 32'd50);
        tick(3);
        gains(-10, 110);
        `CHK(override_indicator, 1'b1)
        rd_reg(REG_CH_GAIN);
        `CHK(d, 32'h006efff6)
        wr_reg(REG_REM_BAL, 32'd13);
        tick(3);
        gains(63, 37);
        wr_reg(REG_REM_BAL, 32'hffffff9c);
        rd_reg(REG_REM_BAL);
        `CHK(d, 32'hffffffc4)
        wr_reg(REG_REM_ROUTE, 32'h15);
        tick(3);
        `CHK(route, 6'h15)
        wr_reg(REG_REM_GAIN, 32'd0);
        wr_reg(REG_REM_ROUTE, 32'h26);
        tick(3);
        `CHK(override_indicator, 1'b0)
        rd_reg(REG_STATUS);
        `CHK(d, 32'h5)
        rd_reg(8'h40);
        `CHK(d, 32'h0)
        wr_reg(REG_REM_GAIN, 32'd50);
        tick(3);
        boot(jp);
        gains(-10, 110);
        `CHK(override_indicator, 1'b1)
        jp.route = 6'h15;
        boot(jp);
        gains(0, 0);
        `CHK(override_indicator, 1'b0)
        `CHK(route, 6'h15)
        jp.route = 6'h3f;
        boot(jp);
        `CHK(route, 6'h30)
        end_of_test();
    end
endmodule // testbench
